// ===== inc/exchange_instr_table_translate_instr_pkg.sv
// constants and types for the exchange / translate / wait execution unit
// assumes a single core clock; no surrounding package dependencies
package exchange_instr_table_translate_instr_pkg;
    localparam logic [7:0] OP_WAIT      = 8'h9b;
    localparam logic [4:0] OP_EXCHANGE_INSTR_ACC  = 5'h12;   // 0x90..0x97 upper five bits
    localparam logic [7:0] OP_EXCHANGE_INSTR_B    = 8'h86;
    localparam logic [7:0] OP_EXCHANGE_INSTR_W    = 8'h87;
    localparam logic [7:0] OP_TABLE_TRANSLATE_INSTR      = 8'hd7;
    localparam logic [1:0] MOD_REG      = 2'h3;
    localparam logic [15:0] IDX_MASK    = 16'h00ff;
    localparam logic [2:0] REG_AX       = 3'h0;
    localparam logic [2:0] REG_BX       = 3'h3;
    localparam logic [4:0] CLK_NOP      = 5'h01;
    localparam logic [4:0] CLK_XACC     = 5'h03;
    localparam logic [4:0] CLK_XREG     = 5'h04;
    localparam logic [4:0] CLK_XMEM     = 5'h11;
    localparam logic [4:0] CLK_XMEM_W8  = 5'h15;
    localparam logic [4:0] CLK_XLAT16   = 5'h0b;
    localparam logic [4:0] CLK_XLAT8    = 5'h0f;
    localparam logic [1:0] SEG_DS       = 2'h3;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_RD    = 3'b001,
        ST_WR    = 3'b010,
        ST_WAITC = 3'b011,
        ST_DONE  = 3'b100
    } exec_state_t;

    typedef enum logic [2:0] {
        K_NONE   = 3'b000,
        K_NOP    = 3'b001,
        K_XACC   = 3'b010,
        K_XREG   = 3'b011,
        K_XMEM   = 3'b100,
        K_TABLE_TRANSLATE_INSTR   = 3'b101
    } instr_kind_t;
endpackage

// ===== core/exchange_instr_regfile.sv
// general register file: eight 16-bit words, read and written only as whole words
// assumes one core clock, two write ports that never collide on one register
`timescale 1ns/1ns
module exchange_instr_regfile (
    // clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_rst_n,
    // read ports
    input  wire logic [2:0]  i_ra,
    input  wire logic [2:0]  i_rb,
    output logic      [15:0] o_da,
    output logic      [15:0] o_db,
    // write ports
    input  wire logic        i_wea,
    input  wire logic [2:0]  i_wa,
    input  wire logic [15:0] i_wda,
    input  wire logic        i_web,
    input  wire logic [2:0]  i_wb,
    input  wire logic [15:0] i_wdb
);
    logic [15:0] regs_q [8];

    assign o_da = regs_q[i_ra];
    assign o_db = regs_q[i_rb];

    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_reg
            always_ff @(posedge i_mclk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    regs_q[g] <= 16'h0000;
                end else if (i_wea && i_wa == 3'(g)) begin
                    regs_q[g] <= i_wda;
                end else if (i_web && i_wb == 3'(g)) begin
                    regs_q[g] <= i_wdb;
                end
            end
        end
    endgenerate
endmodule

// ===== core/exchange_instr_table_translate_instr_exec.sv
// execution unit for the wait, exchange and table translate instructions
// assumes a decoded opcode/modrm/effective address from the front end and a
// memory port that answers each read or write with a one-cycle ack
`timescale 1ns/1ns
module exchange_instr_table_translate_instr_exec
    import exchange_instr_table_translate_instr_pkg::*;
#(
    parameter bit BUS8 = 1'b0
) (
    // clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_rst_n,
    // instruction issue
    input  wire logic        i_issue,
    input  wire logic [7:0]  i_opcode,
    input  wire logic [7:0]  i_modrm,
    input  wire logic [15:0] i_ea,
    input  wire logic        i_seg_ovr,
    input  wire logic [1:0]  i_seg_sel,
    output logic             o_busy,
    output logic             o_done,
    output logic             o_illegal,
    // memory port
    output logic             o_mem_req,
    output logic             o_mem_we,
    output logic             o_mem_word,
    output logic      [1:0]  o_mem_seg,
    output logic      [15:0] o_mem_addr,
    output logic      [15:0] o_mem_wdata,
    input  wire logic        i_mem_ack,
    input  wire logic [15:0] i_mem_rdata,
    // status flags, passed through untouched
    input  wire logic [15:0] i_flags,
    output logic      [15:0] o_flags
);
    import exchange_instr_table_translate_instr_pkg::*;

    exec_state_t state_q, state_d;
    instr_kind_t kind_q;
    logic [4:0]  cnt_q;
    logic [4:0]  need_q;
    logic        word_q;
    logic [2:0]  rega_q, regb_q;
    logic        hia_q, hib_q;
    logic [15:0] addr_q;
    logic [1:0]  seg_q;
    logic [15:0] rdata_q;
    logic        req_q, we_q;
    logic [15:0] wdata_q;
    logic        done_q;

    // decode
    wire [1:0]  dec_mod   = i_modrm[7:6];
    wire [2:0]  dec_reg   = i_modrm[5:3];
    wire [2:0]  dec_rm    = i_modrm[2:0];
    wire        is_wait   = i_opcode == OP_WAIT;
    wire        is_xacc   = i_opcode[7:3] == OP_EXCHANGE_INSTR_ACC && i_opcode != 8'h90;
    wire        is_nopx   = i_opcode == 8'h90;
    wire        is_xrm    = i_opcode == OP_EXCHANGE_INSTR_B || i_opcode == OP_EXCHANGE_INSTR_W;
    wire        is_table_translate_instr   = i_opcode == OP_TABLE_TRANSLATE_INSTR;
    wire        dec_word  = i_opcode[0] | is_xacc;
    wire        rm_is_reg = dec_mod == MOD_REG;
    wire        known     = is_wait | is_xacc | is_nopx | is_xrm | is_table_translate_instr;

    function automatic logic [2:0] breg(input logic [2:0] c);
        breg = {1'b0, c[1:0]};
    endfunction

    instr_kind_t dec_kind;
    logic [4:0]  dec_need;
    always_comb begin
        dec_kind = K_NONE;
        dec_need = CLK_NOP;
        if (is_wait || is_nopx) begin
            dec_kind = K_NOP;
            dec_need = is_nopx ? CLK_XACC : CLK_NOP;
        end else if (is_xacc) begin
            dec_kind = K_XACC;
            dec_need = CLK_XACC;
        end else if (is_xrm && rm_is_reg) begin
            dec_kind = K_XREG;
            dec_need = CLK_XREG;
        end else if (is_xrm) begin
            dec_kind = K_XMEM;
            dec_need = (BUS8 && dec_word) ? CLK_XMEM_W8 : CLK_XMEM;
        end else if (is_table_translate_instr) begin
            dec_kind = K_TABLE_TRANSLATE_INSTR;
            dec_need = BUS8 ? CLK_XLAT8 : CLK_XLAT16;
        end
    end

    // register file access
    logic [15:0] da, db;
    wire [7:0]  byte_a  = hia_q ? da[15:8] : da[7:0];
    wire [7:0]  byte_b  = hib_q ? db[15:8] : db[7:0];
    // long memory waits end the count at once instead of wrapping it
    wire        last    = cnt_q >= need_q;
    wire        fin     = state_q == ST_WAITC && last;
    wire        sw_reg  = fin && (kind_q == K_XACC || kind_q == K_XREG);
    wire        sw_mem  = fin && kind_q == K_XMEM;
    wire        ld_table_translate_instr = fin && kind_q == K_TABLE_TRANSLATE_INSTR;

    // original values are read before either write lands
    wire        same_wd = rega_q == regb_q;
    wire        from_m  = kind_q == K_XMEM;
    wire [7:0]  src_b   = from_m ? rdata_q[7:0] : byte_b;
    wire [15:0] new_a_b = hia_q ? {src_b, da[7:0]} : {da[15:8], src_b};
    // both halves of one register: a single write carries the whole swap
    wire [15:0] same_b  = (hia_q == hib_q) ? da : {da[7:0], da[15:8]};
    wire [15:0] new_a   = word_q ? (from_m ? rdata_q : db)
                        : ((sw_reg && same_wd) ? same_b : new_a_b);
    wire [15:0] new_b   = word_q ? da
                        : (hib_q ? {byte_a, db[7:0]} : {db[15:8], byte_a});
    wire        wea     = sw_reg | sw_mem | ld_table_translate_instr;
    wire [15:0] wda     = ld_table_translate_instr ? {da[15:8], rdata_q[7:0]} : new_a;
    wire        web     = sw_reg && !same_wd;

    exchange_instr_regfile u_rf (
        .i_mclk  (i_mclk),
        .i_rst_n (i_rst_n),
        .i_ra    (rega_q),
        .i_rb    (regb_q),
        .o_da    (da),
        .o_db    (db),
        .i_wea   (wea),
        .i_wa    (rega_q),
        .i_wda   (wda),
        .i_web   (web),
        .i_wb    (regb_q),
        .i_wdb   (new_b)
    );

    // table_translate_instr offset: base register plus zero-extended low byte
    wire [15:0] table_translate_instr_off = db + (da & IDX_MASK);

    // sequencing
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:  if (i_issue && known) begin
                          state_d = (dec_kind == K_XMEM || dec_kind == K_TABLE_TRANSLATE_INSTR) ? ST_RD
                                  : ST_WAITC;
                      end
            ST_RD:    if (i_mem_ack) begin
                          state_d = kind_q == K_XMEM ? ST_WR : ST_WAITC;
                      end
            ST_WR:    if (i_mem_ack) begin
                          state_d = ST_WAITC;
                      end
            ST_WAITC: if (last) begin
                          state_d = ST_IDLE;
                      end
            default:  state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= ST_IDLE;
            cnt_q   <= 5'h00;
        end else begin
            state_q <= state_d;
            cnt_q   <= (state_q == ST_IDLE) ? 5'h01
                     : (cnt_q == 5'h1f) ? cnt_q : cnt_q + 5'h01;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            kind_q <= K_NONE;
            need_q <= CLK_NOP;
            word_q <= 1'b0;
            rega_q <= REG_AX;
            regb_q <= REG_AX;
            hia_q  <= 1'b0;
            hib_q  <= 1'b0;
            addr_q <= 16'h0000;
            seg_q  <= SEG_DS;
        end else if (state_q == ST_IDLE && i_issue && known) begin
            kind_q <= dec_kind;
            need_q <= dec_need;
            word_q <= dec_word;
            hia_q  <= ~dec_word & dec_reg[2];
            hib_q  <= ~dec_word & dec_rm[2];
            rega_q <= is_xacc ? REG_AX : (is_table_translate_instr ? REG_AX
                    : (dec_word ? dec_reg : breg(dec_reg)));
            regb_q <= is_xacc ? i_opcode[2:0] : (is_table_translate_instr ? REG_BX
                    : (dec_word ? dec_rm : breg(dec_rm)));
            addr_q <= i_ea;
            seg_q  <= (is_table_translate_instr && !i_seg_ovr) ? SEG_DS : i_seg_sel;
        end else if (state_q == ST_RD && kind_q == K_TABLE_TRANSLATE_INSTR && cnt_q == 5'h01) begin
            addr_q <= table_translate_instr_off;
        end
    end

    // memory port
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            req_q   <= 1'b0;
            we_q    <= 1'b0;
            wdata_q <= 16'h0000;
            rdata_q <= 16'h0000;
            done_q  <= 1'b0;
        end else begin
            req_q   <= state_d == ST_RD || state_d == ST_WR;
            we_q    <= state_d == ST_WR;
            done_q  <= fin;
            if (state_q == ST_RD && i_mem_ack) begin
                rdata_q <= i_mem_rdata;
                wdata_q <= word_q ? da : {8'h00, byte_a};
            end
        end
    end

    assign o_mem_req   = req_q && !(state_q == ST_RD && kind_q == K_TABLE_TRANSLATE_INSTR && cnt_q == 5'h01);
    assign o_mem_we    = we_q;
    assign o_mem_word  = word_q;
    assign o_mem_seg   = seg_q;
    assign o_mem_addr  = addr_q;
    assign o_mem_wdata = wdata_q;
    assign o_busy      = state_q != ST_IDLE;
    assign o_done      = done_q;
    assign o_illegal   = i_issue && state_q == ST_IDLE && !known;
    assign o_flags     = i_flags;

    // checks
    sequence s_wait_issue;
        state_q == ST_IDLE && i_issue && is_wait;
    endsequence
    sequence s_done_next;
        ##1 fin ##1 o_done;
    endsequence

    chk_wait_is_nop: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        s_wait_issue |-> s_done_next)
        else $error("wait did not finish in one clock");
    chk_xacc_three: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (state_q == ST_IDLE && i_issue && is_xacc) |-> ##3 sw_reg)
        else $error("accumulator exchange not three clocks");
    chk_xreg_four: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (state_q == ST_IDLE && i_issue && is_xrm && rm_is_reg) |-> ##4 sw_reg)
        else $error("register exchange not four clocks");
    chk_flags_kept: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        o_flags == i_flags)
        else $error("status flags changed");
    chk_table_translate_instr_seg: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (state_q == ST_IDLE && i_issue && is_table_translate_instr && !i_seg_ovr) |=> seg_q == SEG_DS)
        else $error("translate not in data segment");
    chk_table_translate_instr_len: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        ld_table_translate_instr |-> cnt_q == (BUS8 ? CLK_XLAT8 : CLK_XLAT16))
        else $error("translate length wrong");
    chk_xmem_len: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        sw_mem |-> cnt_q == ((BUS8 && word_q) ? CLK_XMEM_W8 : CLK_XMEM))
        else $error("memory exchange length wrong");
    chk_swap_vals: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (sw_reg && word_q && !same_wd) |=> (da == $past(db) && db == $past(da)))
        else $error("word exchange lost a value");
    chk_table_translate_instr_load: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        ld_table_translate_instr |=> da[7:0] == $past(rdata_q[7:0]))
        else $error("translate byte not loaded");
endmodule

// ===== tb/mem_model.sv
// partner memory for the exchange/translate unit, acking after a set stall
// assumes each request is held until its ack, as the unit's memory port does
`timescale 1ns/1ns
module mem_model (
    // clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_rst_n,
    // request side
    input  wire logic        i_req,
    input  wire logic        i_we,
    input  wire logic        i_word,
    input  wire logic [15:0] i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic [3:0]  i_stall,
    // answer side
    output logic             o_ack,
    output logic      [15:0] o_rdata
);
    logic [15:0] mem [logic [15:0]];
    logic [15:0] data_q;
    logic [15:0] old;
    logic [3:0]  wait_q;
    logic        ack_q;

    // outside an ack the data lines show the inverse, never a stale match
    assign o_ack   = ack_q;
    assign o_rdata = ack_q ? data_q : ~data_q;

    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ack_q  <= 1'b0;
            wait_q <= 4'h0;
            data_q <= 16'h0000;
        end else if (ack_q || !i_req) begin
            ack_q  <= 1'b0;
            wait_q <= 4'h0;
        end else if (wait_q == i_stall) begin
            old = mem.exists(i_addr) ? mem[i_addr] : (i_addr ^ 16'h5a3c);
            ack_q  <= 1'b1;
            data_q <= old;
            if (i_we) begin
                mem[i_addr] = i_word ? i_wdata : {old[15:8], i_wdata[7:0]};
            end
        end else begin
            wait_q <= wait_q + 4'h1;
        end
    end
endmodule

// ===== tb/exchange_instr_table_translate_instr_exec_tb_top.sv
// self-checking bench: random instruction stream against a queue-based model
// runs both bus variants side by side, each with a partner memory from mem_model
`timescale 1ns/1ns
module exchange_instr_table_translate_instr_exec_tb_top;
    import exchange_instr_table_translate_instr_pkg::*;
    logic        i_mclk, i_rst_n, i_issue, i_seg_ovr, i_mem_ack;
    logic [7:0]  i_opcode, i_modrm;
    logic [15:0] i_ea, i_mem_rdata, i_flags, o_mem_addr, o_mem_wdata, o_flags;
    logic [1:0]  i_seg_sel, o_mem_seg;
    logic [3:0]  stall;
    logic        o_busy, o_done, o_illegal, o_mem_req, o_mem_we, o_mem_word;
    int          mismatches, samples_checked;
    logic        o_busy8, o_done8, o_illegal8, i_mem_ack8;
    logic        o_mem_req8, o_mem_we8, o_mem_word8;
    logic [15:0] o_mem_addr8, o_mem_wdata8, i_mem_rdata8, o_flags8;
    logic [15:0] regs [8];
    logic [15:0] bmem [logic [15:0]];
    logic [17:0] rd_q [$];
    logic [32:0] wr_q [$];

    exchange_instr_table_translate_instr_exec #(.BUS8(1'b0)) uut (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
        .i_issue(i_issue), .i_opcode(i_opcode), .i_modrm(i_modrm), .i_ea(i_ea),
        .i_seg_ovr(i_seg_ovr), .i_seg_sel(i_seg_sel), .o_busy(o_busy), .o_done(o_done),
        .o_illegal(o_illegal), .o_mem_req(o_mem_req), .o_mem_we(o_mem_we),
        .o_mem_word(o_mem_word), .o_mem_seg(o_mem_seg), .o_mem_addr(o_mem_addr),
        .o_mem_wdata(o_mem_wdata), .i_mem_ack(i_mem_ack), .i_mem_rdata(i_mem_rdata),
        .i_flags(i_flags), .o_flags(o_flags));
    mem_model mem (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_req(o_mem_req), .i_we(o_mem_we),
        .i_word(o_mem_word), .i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .i_stall(stall),
        .o_ack(i_mem_ack), .o_rdata(i_mem_rdata));
    // same stream on the 8-bit bus variant, with its own memory
    exchange_instr_table_translate_instr_exec #(.BUS8(1'b1)) uut8 (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
        .i_issue(i_issue), .i_opcode(i_opcode), .i_modrm(i_modrm), .i_ea(i_ea),
        .i_seg_ovr(i_seg_ovr), .i_seg_sel(i_seg_sel), .o_busy(o_busy8), .o_done(o_done8),
        .o_illegal(o_illegal8), .o_mem_req(o_mem_req8), .o_mem_we(o_mem_we8),
        .o_mem_word(o_mem_word8), .o_mem_seg(), .o_mem_addr(o_mem_addr8),
        .o_mem_wdata(o_mem_wdata8), .i_mem_ack(i_mem_ack8), .i_mem_rdata(i_mem_rdata8),
        .i_flags(i_flags), .o_flags(o_flags8));
    mem_model mem8 (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_req(o_mem_req8),
        .i_we(o_mem_we8), .i_word(o_mem_word8), .i_addr(o_mem_addr8),
        .i_wdata(o_mem_wdata8), .i_stall(stall), .o_ack(i_mem_ack8), .o_rdata(i_mem_rdata8));

    initial begin
        i_mclk = 1'b0;
        forever #20 i_mclk = ~i_mclk;
    end

    // completed memory transfers as seen at the port
    always @(posedge i_mclk) begin
        if (i_rst_n && o_mem_req && i_mem_ack) begin
            if (o_mem_we) wr_q.push_back({o_mem_word, o_mem_addr, o_mem_wdata});
            else rd_q.push_back({o_mem_seg, o_mem_addr});
        end
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic cmp_rng(input int got, input int lo, input int hi, input string what);
        samples_checked++;
        if (got < lo || got > hi) begin
            mismatches++;
            $display("[FAIL] %0t %s count %0d not in %0d..%0d", $time, what, got, lo, hi);
        end
    endtask

    function automatic logic [7:0] get8(input logic [2:0] c);
        return c[2] ? regs[c[1:0]][15:8] : regs[c[1:0]][7:0];
    endfunction

    task automatic set8(input logic [2:0] c, input logic [7:0] v);
        if (c[2]) regs[c[1:0]][15:8] = v;
        else regs[c[1:0]][7:0] = v;
    endtask

    task automatic run(input logic [7:0] op, input logic [7:0] mr, input logic [15:0] ea,
                       input logic ovr, input logic [1:0] sel);
        int n, lo, acc, k, n8, lo8;
        logic [15:0] a, t, w;
        logic [2:0] r, m;
        logic xw, xmem, known, isx;
        bit d16, d8;
        r = mr[5:3];
        m = mr[2:0];
        n = 0;
        n8 = 0;
        lo = 0;
        d16 = 1'b0;
        d8 = 1'b0;
        acc = 0;
        isx = (op == OP_EXCHANGE_INSTR_B) || (op == OP_EXCHANGE_INSTR_W);
        xmem = isx && (mr[7:6] != MOD_REG);
        known = 1'b1;
        rd_q.delete();
        wr_q.delete();
        @(negedge i_mclk);
        {i_opcode, i_modrm, i_ea, i_seg_ovr, i_seg_sel} = {op, mr, ea, ovr, sel};
        i_flags = 16'($urandom);
        stall = 4'($urandom_range(0, 3));
        i_issue = 1'b1;
        if (op == OP_WAIT) begin
            lo = CLK_NOP;
        end else if (op[7:3] == OP_EXCHANGE_INSTR_ACC) begin
            t = regs[0];
            regs[0] = regs[op[2:0]];
            regs[op[2:0]] = t;
            lo = CLK_XACC;
        end else if (isx && !xmem) begin
            lo = CLK_XREG;
            if (op[0]) begin
                t = regs[r];
                regs[r] = regs[m];
                regs[m] = t;
            end else begin
                t[7:0] = get8(r);
                set8(r, get8(m));
                set8(m, t[7:0]);
            end
        end else if (isx) begin
            lo = CLK_XMEM;
            acc = 2;
            t = bmem.exists(ea) ? bmem[ea] : (ea ^ 16'h5a3c);
            w = op[0] ? regs[r] : {8'h00, get8(r)};
            bmem[ea] = op[0] ? w : {t[15:8], w[7:0]};
            if (op[0]) regs[r] = t;
            else set8(r, t[7:0]);
        end else if (op == OP_TABLE_TRANSLATE_INSTR) begin
            lo = CLK_XLAT16;
            acc = 1;
            a = regs[REG_BX] + (regs[REG_AX] & IDX_MASK);
            t = bmem.exists(a) ? bmem[a] : (a ^ 16'h5a3c);
            regs[REG_AX][7:0] = t[7:0];
        end else begin
            known = 1'b0;
        end
        lo8 = lo;
        if (xmem && op[0]) lo8 = CLK_XMEM_W8;
        if (op == OP_TABLE_TRANSLATE_INSTR) lo8 = CLK_XLAT8;
        #1;
        cmp(o_illegal, !known, "illegal flag");
        cmp(o_illegal8, !known, "illegal flag bus8");
        @(negedge i_mclk);
        i_issue = 1'b0;
        for (k = 0; k < 200 && known && !(d16 && d8); k++) begin
            cmp(o_flags, i_flags, "flags");
            cmp(o_flags8, i_flags, "flags bus8");
            if (o_done === 1'b1) d16 = 1'b1;
            if (o_done8 === 1'b1) d8 = 1'b1;
            if (!d16 && o_busy === 1'b1) n++;
            if (!d8 && o_busy8 === 1'b1) n8++;
            if (!(d16 && d8)) @(negedge i_mclk);
        end
        if (k == 200) begin
            cmp(0, 1, "timeout");
            conclude();
        end
        if (!known) cmp(o_busy, 0, "refused busy");
        if (acc == 0) cmp(n, lo, "clocks");
        else cmp_rng(n, lo, lo + acc * (stall + 2), "clocks");
        if (acc == 0) cmp(n8, lo8, "clocks bus8");
        else cmp_rng(n8, lo8, lo8 + acc * (stall + 2), "clocks bus8");
        cmp(rd_q.size() + wr_q.size(), acc, "access count");
        if (xmem && rd_q.size() == 1 && wr_q.size() == 1) begin
            cmp(rd_q[0][15:0], ea, "exchange_instr read addr");
            cmp(wr_q[0][32:16], {op[0], ea}, "exchange_instr write");
            cmp(op[0] ? wr_q[0][15:0] : wr_q[0][7:0], w, "exchange_instr data");
        end
        if (op == OP_TABLE_TRANSLATE_INSTR && rd_q.size() == 1) begin
            cmp(rd_q[0], {ovr ? sel : SEG_DS, a}, "table read");
        end
    endtask

    initial begin
        {i_rst_n, i_issue, i_seg_ovr, i_opcode, i_modrm, i_ea, i_seg_sel, i_flags} = '0;
        stall = 4'h0;
        mismatches = 0;
        samples_checked = 0;
        void'($urandom(64));
        foreach (regs[i]) regs[i] = 16'h0000;
        repeat (5) @(posedge i_mclk);
        @(negedge i_mclk);
        i_rst_n = 1'b1;
        // load each word register from memory; the written data reads back the reset zero
        for (int i = 0; i < 8; i++) run(OP_EXCHANGE_INSTR_W, {2'h0, 3'(i), 3'h6}, 16'h0100 + 16'(i), 0, 0);
        for (int i = 0; i < 8; i++) run({OP_EXCHANGE_INSTR_ACC, 3'(i)}, 8'h00, 16'h0000, 0, 0);
        run(OP_WAIT, 8'h00, 16'h0000, 0, 0);
        run(8'h0f, 8'h00, 16'h0000, 0, 0);
        for (int i = 0; i < 300; i++) begin
            case ($urandom_range(0, 5))
                0: run(OP_WAIT, 8'($urandom), 16'($urandom), 0, 0);
                1: run({OP_EXCHANGE_INSTR_ACC, 3'($urandom)}, 8'h00, 16'h0000, 0, 0);
                2: run(OP_EXCHANGE_INSTR_B, 8'($urandom), 16'($urandom), 0, 0);
                3: run(OP_EXCHANGE_INSTR_W, 8'($urandom), 16'($urandom), 0, 0);
                4: run(OP_TABLE_TRANSLATE_INSTR, 8'h00, 16'($urandom), 1'($urandom), 2'($urandom));
                default: run(8'h8e, 8'($urandom), 16'h0000, 0, 0);
            endcase
        end
        for (int i = 0; i < 8; i++) run(OP_EXCHANGE_INSTR_W, {2'h0, 3'(i), 3'h6}, 16'h0200 + 16'(i), 0, 0);
        conclude();
    end
endmodule
